// >>> hdl/timer_gctl_pkg.sv
// Package: register map, field layout and types of the timer global control block
`default_nettype none
package timer_gctl_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register byte offsets
  localparam logic [7:0] OFS_GLOBAL_CONTROL = 8'h00;
  localparam logic [7:0] OFS_UPPER_PERIOD = 8'h04;
  localparam logic [7:0] OFS_UPPER_CONFIG = 8'h08;
  localparam logic [7:0] OFS_UPPER_COUNT = 8'h0C;
  localparam logic [7:0] OFS_UPPER_RELOAD = 8'h10;

  // Global control field positions
  localparam int POS_LOWER_RUN = 0;
  localparam int POS_UPPER_RUN = 1;
  localparam int POS_MODE_LO = 2;
  localparam int POS_MODE_HI = 3;
  localparam int POS_NEW_FEAT = 4;
  localparam int POS_PSC_LO = 8;
  localparam int POS_PSC_HI = 11;
  localparam int POS_DIV_LO = 12;
  localparam int POS_DIV_HI = 15;

  // Upper config field positions
  localparam int POS_ENA_LO = 0;
  localparam int POS_ENA_HI = 1;
  localparam int POS_STOPPED = 2;

  // Values after reset
  localparam logic [3:0] RST_PRESCALE = 4'h0;
  localparam logic [3:0] RST_DIVIDE = 4'h0;
  localparam logic [31:0] RST_PERIOD = 32'hFFFFFFFF;
  localparam logic [31:0] RST_RELOAD = 32'h00000000;
  localparam logic [31:0] RST_COUNT = 32'h00000000;
  localparam logic [31:0] RDATA_ZERO = 32'h00000000;

  typedef enum logic [1:0] {
    CM_GP64 = 2'h0,
    CM_DUAL_UNCHAINED = 2'h1,
    CM_WDOG64 = 2'h2,
    CM_DUAL_CHAINED = 2'h3
  } counter_mode_t;

  typedef enum logic [1:0] {
    EM_STOPPED = 2'h0,
    EM_ONCE = 2'h1,
    EM_CONTINUOUS = 2'h2,
    EM_CONT_RELOAD = 2'h3
  } enable_mode_t;

  typedef struct packed {
    logic [3:0] upper_prescale;
    logic new_features_enable;
    counter_mode_t counter_mode;
    logic upper_half_run;
    logic lower_half_run;
  } global_control_t;

  localparam global_control_t RST_GLOBAL_CONTROL = '{
    upper_prescale: RST_PRESCALE,
    new_features_enable: 1'b0,
    counter_mode: CM_GP64,
    upper_half_run: 1'b0,
    lower_half_run: 1'b0
  };

endpackage
`default_nettype wire

// >>> hdl/timer_global_control_prescale.sv
// Global control, prescaler and upper-half counter of the split 64-bit timer
`default_nettype none

module timer_global_control_prescale
  import timer_gctl_pkg::*;
#(
  parameter int CNT_W = 32
) (
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  input wire logic [ADDR_W-1:0] ADDR_I,
  input wire logic [DATA_W-1:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [DATA_W-1:0] RDATA_O,
  input wire logic WDOG_ACTIVE_I,
  output logic UPPER_HALF_RESET_O,
  output logic LOWER_HALF_RESET_O,
  output logic [1:0] COUNTER_MODE_O,
  output logic NEW_FEATURES_O,
  output logic [CNT_W-1:0] UPPER_COUNT_O,
  output logic UPPER_TICK_O,
  output logic UPPER_MATCH_O
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  global_control_t gctl_ff;
  enable_mode_t upper_enable_mode_ff;
  logic [3:0] upper_divide_count_ff;
  logic [CNT_W-1:0] upper_count_ff;
  logic [CNT_W-1:0] upper_period_ff;
  logic [CNT_W-1:0] upper_reload_ff;
  logic upper_tick_ff;
  logic upper_stopped_ff;
  logic [DATA_W-1:0] rdata_ff;

  logic wr_gctl;
  logic wr_period;
  logic wr_config;
  logic wr_reload;
  logic upper_running;
  logic upper_match;
  logic divide_match;
  logic reload_active;
  enable_mode_t wr_enable_mode;
  logic [DATA_W-1:0] nxt_rdata;
  logic [DATA_W-1:0] gctl_view;
  logic [DATA_W-1:0] config_view;
  logic wr_run_ok;
  logic nxt_upper_run;
  logic upper_hold;
  logic upper_tick;
  logic period_reload;
  logic [3:0] wr_prescale;
  counter_mode_t wr_counter_mode;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode

  assign wr_gctl = WR_I && (ADDR_I == OFS_GLOBAL_CONTROL);
  assign wr_period = WR_I && (ADDR_I == OFS_UPPER_PERIOD);
  assign wr_config = WR_I && (ADDR_I == OFS_UPPER_CONFIG);
  assign wr_reload = WR_I && (ADDR_I == OFS_UPPER_RELOAD);
  assign wr_enable_mode = enable_mode_t'(WDATA_I[POS_ENA_HI:POS_ENA_LO]);
  assign wr_prescale = WDATA_I[POS_PSC_HI:POS_PSC_LO];
  assign wr_counter_mode = counter_mode_t'(WDATA_I[POS_MODE_HI:POS_MODE_LO]);
  // Watchdog active comes from logic on this clock, so it is used unsynchronised
  assign wr_run_ok = wr_gctl && !WDOG_ACTIVE_I;

  ////////////////////////////////////////////////////////////////////////////
  // Upper half hold

  // Hold follows the run bit's next value, so a cleared bit resets the half
  // on the very edge that writes it instead of one cycle later
  assign nxt_upper_run = wr_run_ok ? WDATA_I[POS_UPPER_RUN] : gctl_ff.upper_half_run;
  assign upper_hold = RST_I || !nxt_upper_run;

  ////////////////////////////////////////////////////////////////////////////
  // Global control register

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      gctl_ff <= RST_GLOBAL_CONTROL;
    end else if (wr_gctl) begin
      gctl_ff.upper_prescale <= wr_prescale;
      gctl_ff.new_features_enable <= WDATA_I[POS_NEW_FEAT];
      gctl_ff.counter_mode <= wr_counter_mode;
      // Half resets frozen once the watchdog is active
      if (wr_run_ok) begin
        gctl_ff.upper_half_run <= WDATA_I[POS_UPPER_RUN];
        gctl_ff.lower_half_run <= WDATA_I[POS_LOWER_RUN];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Upper half configuration registers

  // A software period write wins over a reload in the same cycle
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      upper_period_ff <= RST_PERIOD[CNT_W-1:0];
    end else if (wr_period) begin
      upper_period_ff <= WDATA_I[CNT_W-1:0];
    end else if (period_reload) begin
      upper_period_ff <= upper_reload_ff;
    end
  end

  // Reload value waits here until a wrapping step in reload mode
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      upper_reload_ff <= RST_RELOAD[CNT_W-1:0];
    end else if (wr_reload) begin
      upper_reload_ff <= WDATA_I[CNT_W-1:0];
    end
  end

  // Any enable-mode write, even an unchanged one, also rearms the one-shot except in the cycle of a hardware stop
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      upper_enable_mode_ff <= EM_STOPPED;
    end else if (wr_config) begin
      upper_enable_mode_ff <= wr_enable_mode;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Run qualification

  // Reload is an extended feature; legacy mode runs it as plain continuous
  assign reload_active = (upper_enable_mode_ff == EM_CONT_RELOAD)
                         && gctl_ff.new_features_enable;
  always_comb begin
    upper_running = 1'b0;
    unique case (upper_enable_mode_ff)
      EM_STOPPED: begin
        upper_running = 1'b0;
      end
      EM_ONCE, EM_CONTINUOUS, EM_CONT_RELOAD: begin
        upper_running = gctl_ff.upper_half_run && !upper_stopped_ff;
      end
    endcase
  end
  // Match uses the live period, so a period write takes effect at once
  assign upper_match = (upper_count_ff == upper_period_ff);
  assign divide_match = (upper_divide_count_ff == gctl_ff.upper_prescale);
  // A step left over from before a stop or a change to the stopped mode must not count
  assign upper_tick = upper_tick_ff && upper_running;
  assign period_reload = reload_active && upper_tick && upper_match;

  ////////////////////////////////////////////////////////////////////////////
  // Divide-down prescaler

  // Frozen while the half is stopped, so a rearm keeps the prescale phase
  always_ff @(posedge CLK_SYS_I) begin
    if (upper_hold) begin
      upper_divide_count_ff <= RST_DIVIDE;
    end else if (upper_running) begin
      if (divide_match) begin
        upper_divide_count_ff <= RST_DIVIDE;
      end else begin
        upper_divide_count_ff <= upper_divide_count_ff + 4'h1;
      end
    end
  end

  // Count step lands one cycle after the divide match
  always_ff @(posedge CLK_SYS_I) begin
    if (upper_hold) begin
      upper_tick_ff <= 1'b0;
    end else begin
      upper_tick_ff <= upper_running && divide_match;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Upper count and one-shot stop

  always_ff @(posedge CLK_SYS_I) begin
    if (upper_hold) begin
      upper_count_ff <= RST_COUNT[CNT_W-1:0];
    end else if (upper_tick) begin
      if (!upper_match) begin
        upper_count_ff <= upper_count_ff + {{(CNT_W-1){1'b0}}, 1'b1};
      end else begin
        unique case (upper_enable_mode_ff)
          EM_ONCE: begin
            upper_count_ff <= upper_count_ff;
          end
          EM_CONTINUOUS, EM_CONT_RELOAD: begin
            upper_count_ff <= RST_COUNT[CNT_W-1:0];
          end
          EM_STOPPED: begin
            upper_count_ff <= upper_count_ff;
          end
        endcase
      end
    end
  end

  // A new enable-mode write rearms a finished one-shot
  // The hardware stop wins over a rearm written in the same cycle
  always_ff @(posedge CLK_SYS_I) begin
    if (upper_hold) begin
      upper_stopped_ff <= 1'b0;
    end else if (upper_running && (upper_enable_mode_ff == EM_ONCE) && upper_match) begin
      upper_stopped_ff <= 1'b1;
    end else if (wr_config) begin
      upper_stopped_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path

  // Divide count is live status; reserved bits always read zero
  always_comb begin
    gctl_view = RDATA_ZERO;
    gctl_view[POS_DIV_HI:POS_DIV_LO] = upper_divide_count_ff;
    gctl_view[POS_PSC_HI:POS_PSC_LO] = gctl_ff.upper_prescale;
    gctl_view[POS_NEW_FEAT] = gctl_ff.new_features_enable;
    gctl_view[POS_MODE_HI:POS_MODE_LO] = gctl_ff.counter_mode;
    gctl_view[POS_UPPER_RUN] = gctl_ff.upper_half_run;
    gctl_view[POS_LOWER_RUN] = gctl_ff.lower_half_run;
  end

  // Stopped flag shows software that a one-shot has finished
  always_comb begin
    config_view = RDATA_ZERO;
    config_view[POS_ENA_HI:POS_ENA_LO] = upper_enable_mode_ff;
    config_view[POS_STOPPED] = upper_stopped_ff;
  end

  always_comb begin
    nxt_rdata = RDATA_ZERO;
    // Unmapped offsets and idle cycles read zero
    if (RD_I) begin
      unique case (ADDR_I)
        OFS_GLOBAL_CONTROL: begin
          nxt_rdata = gctl_view;
        end
        OFS_UPPER_PERIOD: begin
          nxt_rdata[CNT_W-1:0] = upper_period_ff;
        end
        OFS_UPPER_CONFIG: begin
          nxt_rdata = config_view;
        end
        OFS_UPPER_COUNT: begin
          nxt_rdata[CNT_W-1:0] = upper_count_ff;
        end
        OFS_UPPER_RELOAD: begin
          nxt_rdata[CNT_W-1:0] = upper_reload_ff;
        end
        default: begin
          nxt_rdata = RDATA_ZERO;
        end
      endcase
    end
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      rdata_ff <= RDATA_ZERO;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign RDATA_O = rdata_ff;
  assign UPPER_HALF_RESET_O = !gctl_ff.upper_half_run;
  assign LOWER_HALF_RESET_O = !gctl_ff.lower_half_run;
  assign COUNTER_MODE_O = gctl_ff.counter_mode;
  assign NEW_FEATURES_O = gctl_ff.new_features_enable;
  assign UPPER_COUNT_O = upper_count_ff;
  assign UPPER_TICK_O = upper_tick;
  assign UPPER_MATCH_O = upper_tick && upper_match;

endmodule
`default_nettype wire

// >>> verif/timer_gctl_sva.sv
// Concurrent checks on the ports of the timer global control block
`default_nettype none
module timer_gctl_sva
  import timer_gctl_pkg::*;
#(
  parameter int CNT_W = 32
) (
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  input wire logic [ADDR_W-1:0] ADDR_I,
  input wire logic [DATA_W-1:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire logic [DATA_W-1:0] RDATA_O,
  input wire logic WDOG_ACTIVE_I,
  input wire logic UPPER_HALF_RESET_O,
  input wire logic LOWER_HALF_RESET_O,
  input wire logic [1:0] COUNTER_MODE_O,
  input wire logic NEW_FEATURES_O,
  input wire logic [CNT_W-1:0] UPPER_COUNT_O,
  input wire logic UPPER_TICK_O,
  input wire logic UPPER_MATCH_O
);
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (RST_I);
  sequence s_gctl_wr;
    WR_I && ADDR_I == OFS_GLOBAL_CONTROL;
  endsequence
  AST_HELD: assert property (UPPER_HALF_RESET_O |-> UPPER_COUNT_O == '0 && !UPPER_TICK_O)
    else $error("upper count or tick active while upper half held");
  AST_STEP: assert property (UPPER_TICK_O && !UPPER_MATCH_O && !WR_I |=>
    UPPER_COUNT_O == $past(UPPER_COUNT_O) + 1'b1) else $error("count did not step after tick");
  AST_HOLD: assert property (!UPPER_TICK_O && !WR_I |=> $stable(UPPER_COUNT_O))
    else $error("count moved without tick");
  AST_MATCH: assert property (UPPER_MATCH_O |-> UPPER_TICK_O ##1
    (UPPER_COUNT_O == '0 || $stable(UPPER_COUNT_O))) else $error("wrong count after match");
  AST_RD_IDLE: assert property (!RD_I |=> RDATA_O == '0)
    else $error("read data not zero outside read");
  AST_FIELDS: assert property (s_gctl_wr |=> COUNTER_MODE_O == $past(WDATA_I[3:2]) &&
    NEW_FEATURES_O == $past(WDATA_I[4])) else $error("mode fields not written");
  AST_RUN: assert property (s_gctl_wr ##0 !WDOG_ACTIVE_I |=>
    UPPER_HALF_RESET_O != $past(WDATA_I[1]) && LOWER_HALF_RESET_O != $past(WDATA_I[0]))
    else $error("run bits not written");
  AST_WDOG: assert property (s_gctl_wr ##0 WDOG_ACTIVE_I |=>
    $stable(UPPER_HALF_RESET_O) && $stable(LOWER_HALF_RESET_O)) else $error("run bits changed");
  AST_KEEP: assert property (!WR_I |=> $stable(COUNTER_MODE_O) && $stable(NEW_FEATURES_O))
    else $error("mode fields changed without write");
endmodule
bind timer_global_control_prescale timer_gctl_sva #(.CNT_W(CNT_W)) u_sva (
  .CLK_SYS_I(CLK_SYS_I), .RST_I(RST_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I),
  .RD_I(RD_I), .RDATA_O(RDATA_O), .WDOG_ACTIVE_I(WDOG_ACTIVE_I),
  .UPPER_HALF_RESET_O(UPPER_HALF_RESET_O), .LOWER_HALF_RESET_O(LOWER_HALF_RESET_O),
  .COUNTER_MODE_O(COUNTER_MODE_O), .NEW_FEATURES_O(NEW_FEATURES_O),
  .UPPER_COUNT_O(UPPER_COUNT_O), .UPPER_TICK_O(UPPER_TICK_O), .UPPER_MATCH_O(UPPER_MATCH_O));
`default_nettype wire

// >>> verif/timer_global_control_prescale_tb.sv
// Self-checking testbench of the timer global control block
`default_nettype none
module timer_global_control_prescale_tb import timer_gctl_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, wr, rd, wdog, uhr, lhr, nf, tick, match;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, cnt, d, r, rnd, mx, mn;
  logic [1:0] mode;
  logic [3:0] p;
  int num_errors = 0;
  int checks = 0;
  int n, nt, nm;
  timer_global_control_prescale #(.CNT_W(32)) u_timer_global_control_prescale (
    .CLK_SYS_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
    .RDATA_O(rdata), .WDOG_ACTIVE_I(wdog), .UPPER_HALF_RESET_O(uhr), .LOWER_HALF_RESET_O(lhr),
    .COUNTER_MODE_O(mode), .NEW_FEATURES_O(nf), .UPPER_COUNT_O(cnt), .UPPER_TICK_O(tick),
    .UPPER_MATCH_O(match));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] exp_out(input logic [31:0] v);
    return {27'h0, v[4], v[3:2], ~v[1], ~v[0]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wrt(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
    @(negedge clk);
  endtask
  task automatic rdd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    v = rdata;
  endtask
  // Clocks from one count step to the next
  task automatic gap(output int k);
    logic [31:0] c;
    c = cnt;
    k = 0;
    repeat (40) begin
      @(negedge clk);
      k++;
      if (cnt !== c) break;
    end
  endtask
  task automatic span(output logic [31:0] hi, output logic [31:0] lo);
    hi = 32'h0;
    lo = 32'hFFFFFFFF;
    repeat (24) begin
      @(negedge clk);
      if (cnt > hi) hi = cnt;
      if (cnt < lo) lo = cnt;
    end
  endtask
  task automatic finish_test();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    repeat (6000) @(posedge clk);
    num_errors++;
    finish_test();
  end
  initial begin
    {rst, wr, rd, wdog, addr, wdata} = {1'b1, 3'b000, 8'h00, 32'h0};
    rnd = 32'hC579FC2A;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk(exp_out(32'h0), {27'h0, nf, mode, uhr, lhr});
    rdd(OFS_GLOBAL_CONTROL, r);
    chk(r, 32'h0);
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      d = {rnd[31:4], 4'(i * 5)};
      wrt(OFS_GLOBAL_CONTROL, d);
      chk({27'h0, nf, mode, uhr, lhr}, exp_out(d));
      rdd(OFS_GLOBAL_CONTROL, r);
      chk(r, d & 32'h00000F1F);
    end
    @(posedge clk) wdog <= 1'b1;
    wrt(OFS_GLOBAL_CONTROL, 32'h00000008);
    chk({27'h0, nf, mode, uhr, lhr}, {27'h0, 3'b010, 2'b00});
    @(posedge clk) wdog <= 1'b0;
    for (int k = 0; k < 3; k++) begin
      rnd = lfsr(rnd);
      p = (k == 0) ? 4'h0 : (k == 1) ? 4'hF : rnd[3:0];
      wrt(OFS_GLOBAL_CONTROL, 32'h0);
      wrt(OFS_UPPER_PERIOD, 32'hFFFFFFFF);
      wrt(OFS_UPPER_CONFIG, 32'h2);
      wrt(OFS_GLOBAL_CONTROL, {20'h0, p, 8'h03});
      gap(n);
      gap(n);
      chk(32'(n), 32'(p) + 32'h1);
    end
    wrt(OFS_GLOBAL_CONTROL, 32'h0);
    wrt(OFS_UPPER_PERIOD, 32'h3);
    wrt(OFS_UPPER_CONFIG, 32'h1);
    wrt(OFS_GLOBAL_CONTROL, 32'h3);
    nt = 0;
    nm = 0;
    repeat (30) begin
      @(negedge clk);
      if (tick === 1'b1) nt++;
      if (match === 1'b1) nm++;
    end
    chk(cnt, 32'h3);
    chk(32'(nt), 32'h4);
    chk(32'(nm), 32'h1);
    wrt(OFS_UPPER_CONFIG, 32'h2);
    span(mx, mn);
    chk(mx, 32'h3);
    chk(mn, 32'h0);
    wrt(OFS_UPPER_RELOAD, 32'h1);
    wrt(OFS_UPPER_CONFIG, 32'h3);
    span(mx, mn);
    chk(mx, 32'h3);
    wrt(OFS_GLOBAL_CONTROL, 32'h13);
    repeat (20) @(negedge clk);
    span(mx, mn);
    chk(mx, 32'h1);
    chk(mn, 32'h0);
    rdd(OFS_UPPER_PERIOD, r);
    chk(r, 32'h1);
    wrt(OFS_UPPER_CONFIG, 32'h0);
    d = cnt;
    repeat (10) @(negedge clk);
    chk(cnt, d);
    rdd(8'h40, r);
    chk(r, 32'h0);
    finish_test();
  end
endmodule
`default_nettype wire
